// >>> pkg/ttq_params.svh
// offsets, field positions, reset values and timing counts of the trigger time qualifier
// What this block does
// - three independent events (main, second, reset), each with its own settings
// - per-channel thresholds, channels 1 to 4, -10 V to 10 V, 1 mV steps
// - window time judging applies only in stay-inside or stay-outside vertical mode
// - inside means between levels; outside means above upper or below lower
// - within mode fires when dwell lies in width minus delta to width plus delta
// - outside mode fires when dwell is below width minus delta or above plus delta
// - shorter mode fires when the window is left before the width has elapsed
// - width is centre in within/outside, maximum in shorter, minimum in longer
// - timeout watches stay high, stay low or any_direction; stay high after reset
// - timeout fires when the chosen level has held for the timeout time
// - interval measures time between two successive qualifying edges
// - interval edges are rising, falling or any_direction; rising after reset
// - interval delta is a tolerance band around the interval width
// - inside fires within width plus or minus delta; outside fires beyond it
// - shorter fires below the interval width; longer fires above it
// - slew uses per-channel lower and upper thresholds, reset -0.1 V and 0.1 V
// - slew timing starts at first threshold crossing, stops at the second
// - slew delta is a time band around the slew rate value
`ifndef TTQ_PARAMS_SVH
`define TTQ_PARAMS_SVH

`define TTQ_NUM_EV 3
`define TTQ_NUM_CH 4
`define TTQ_ADDR_W 8

// timing
`define TTQ_CLK_PS 5000
`define TTQ_TICKS(ps) ((((ps) + `TTQ_CLK_PS - 1) / `TTQ_CLK_PS) < 1 ? 1 : \
   (((ps) + `TTQ_CLK_PS - 1) / `TTQ_CLK_PS))
`define TTQ_WIN_WIDTH_RST_PS 5000
`define TTQ_TO_TIME_RST_PS 100000
`define TTQ_IV_WIDTH_RST_PS 5000
`define TTQ_SL_RATE_RST_PS 100

// per-event word index, event block stride in bytes
`define TTQ_EV_STRIDE 8'h40
`define TTQ_IDX_CTRL 4'h0
`define TTQ_IDX_WIN_WIDTH 4'h1
`define TTQ_IDX_WIN_DELTA 4'h2
`define TTQ_IDX_TO_TIME 4'h3
`define TTQ_IDX_IV_WIDTH 4'h4
`define TTQ_IDX_IV_DELTA 4'h5
`define TTQ_IDX_SL_RATE 4'h6
`define TTQ_IDX_SL_DELTA 4'h7
`define TTQ_IDX_LOWER0 4'h8
`define TTQ_IDX_UPPER0 4'hC
`define TTQ_STAT_BASE 8'hC0
`define TTQ_STAT_LEVELS 8'hD8

// control word fields
`define TTQ_F_TYPE 0
`define TTQ_F_SRC 2
`define TTQ_F_VERT 4
`define TTQ_F_WTIME 6
`define TTQ_F_TOCOND 8
`define TTQ_F_IVMODE 10
`define TTQ_F_IVEDGE 12
`define TTQ_F_SLSLOPE 14
`define TTQ_F_SLMODE 16
`define TTQ_F_EN 31
`define TTQ_CTRL_RST 32'h0003_0400

// thresholds in millivolts
`define TTQ_MV_MIN (-32'sd10000)
`define TTQ_MV_MAX 32'sd10000
`define TTQ_LOWER_RST 16'hFF9C
`define TTQ_UPPER_RST 16'h0064

`define TTQ_RESP_OKAY 2'b00
`define TTQ_RESP_SLVERR 2'b10

`endif

// >>> pkg/ttq_pkg.sv
// types shared by the trigger time qualifier
`default_nettype none
package ttq_pkg;
   typedef enum logic [1:0] {QT_WINDOW, QT_TIMEOUT, QT_INTERVAL, QT_SLEW} ttq_qual_type;
   typedef enum logic [1:0] {VM_ENTER, VM_EXIT, VM_INSIDE, VM_OUTSIDE} ttq_vert_type;
   typedef enum logic [1:0] {JM_WITHIN, JM_OUTSIDE, JM_SHORTER, JM_LONGER} ttq_judge_type;
   typedef enum logic [1:0] {LC_HIGH, LC_LOW, LC_ANY} ttq_level_type;
   typedef enum logic [1:0] {ED_RISE, ED_FALL, ED_ANY} ttq_edge_type;

   typedef struct packed {
      logic above_upper;
      logic below_lower;
   } ttq_cmp_type;

   typedef struct packed {
      logic [15:0] lower_mv;
      logic [15:0] upper_mv;
   } ttq_thr_type;

   typedef struct packed {
      logic enable;
      ttq_qual_type qual;
      logic [1:0] src;
      ttq_vert_type vert;
      ttq_judge_type win_time;
      ttq_level_type to_cond;
      ttq_judge_type iv_mode;
      ttq_edge_type iv_edge;
      ttq_edge_type sl_slope;
      ttq_judge_type sl_mode;
   } ttq_cfg_type;
endpackage : ttq_pkg
`default_nettype wire

// >>> verilog/ttq_sync.sv
// two-stage synchroniser for comparator levels
`timescale 1ns/1ps
`default_nettype none
module ttq_sync #(
   parameter int W = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce_i) begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule : ttq_sync
`default_nettype wire

// >>> verilog/ttq_judge.sv
// compares a measured tick count against width and delta
`timescale 1ns/1ps
`default_nettype none
module ttq_judge #(
   parameter int W = 32
) (
   input wire ttq_pkg::ttq_judge_type mode_i,
   input wire logic [W-1:0] dur_i,
   input wire logic [W-1:0] width_i,
   input wire logic [W-1:0] delta_i,
   output logic hit_o
);
   import ttq_pkg::*;
   logic [W:0] lo;
   logic [W:0] hi;
   logic [W:0] dur;

   always_comb begin
      dur = {1'b0, dur_i};
      lo = (width_i > delta_i) ? {1'b0, width_i - delta_i} : '0;
      hi = {1'b0, width_i} + {1'b0, delta_i};
      case (mode_i)
         JM_WITHIN: hit_o = (dur >= lo) && (dur <= hi);
         JM_OUTSIDE: hit_o = (dur < lo) || (dur > hi);
         JM_SHORTER: hit_o = dur_i < width_i;
         JM_LONGER: hit_o = dur_i > width_i;
         default: hit_o = 1'b0;
      endcase
   end
endmodule : ttq_judge
`default_nettype wire

// >>> verilog/ttq_top.sv
// trigger time qualifier: register slave plus three event engines
`timescale 1ns/1ps
`default_nettype none
`include "ttq_params.svh"
module ttq_top #(
   parameter int CNT_W = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire ttq_pkg::ttq_cmp_type [`TTQ_NUM_EV*`TTQ_NUM_CH-1:0] cmp_i,
   output ttq_pkg::ttq_thr_type [`TTQ_NUM_EV*`TTQ_NUM_CH-1:0] thr_o,
   output logic [`TTQ_NUM_EV-1:0] trig_o,
   input wire logic [`TTQ_ADDR_W-1:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [`TTQ_ADDR_W-1:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready
);
   import ttq_pkg::*;

   localparam int NEV = `TTQ_NUM_EV;
   localparam int NCH = `TTQ_NUM_CH;
   localparam int NCMP = NEV * NCH;
   localparam int NREG = NEV * 16;
   localparam int CMPW = $bits(ttq_cmp_type) * NCMP;

   // register file and bus state
   logic [31:0] regs_q [NREG];
   logic [31:0] regs_d [NREG];
   logic aw_v_q, aw_v_d, w_v_q, w_v_d, b_v_q, b_v_d, r_v_q, r_v_d;
   logic [`TTQ_ADDR_W-1:0] aw_a_q, aw_a_d;
   logic [31:0] w_d_q, w_d_d, r_d_q, r_d_d;
   logic [3:0] w_s_q, w_s_d;
   logic [1:0] b_r_q, b_r_d, r_r_q, r_r_d;
   logic [NEV-1:0] cfg_wr_q, cfg_wr_d;

   // event results
   logic [NEV-1:0] fire;
   logic [NEV-1:0] meas_v;
   logic [CNT_W-1:0] meas [NEV];
   logic [NEV-1:0] fire_q;
   logic [CNT_W-1:0] last_q [NEV];
   logic [CNT_W-1:0] last_d [NEV];
   logic [15:0] count_q [NEV];
   logic [15:0] count_d [NEV];

   logic [CMPW-1:0] cmp_raw;
   logic [CMPW-1:0] cmp_sv;
   ttq_cmp_type [NCMP-1:0] cmp_s;

   assign cmp_raw = cmp_i;
   assign cmp_s = cmp_sv;

   ttq_sync #(.W(CMPW)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .d_i(cmp_raw),
      .q_o(cmp_sv)
   );

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [31:0] clamp_mv(input logic [31:0] v);
      logic signed [31:0] s;
      s = $signed(v);
      if (s < `TTQ_MV_MIN) begin
         s = `TTQ_MV_MIN;
      end else if (s > `TTQ_MV_MAX) begin
         s = `TTQ_MV_MAX;
      end
      return {16'h0000, s[15:0]};
   endfunction : clamp_mv

   function automatic logic [31:0] reg_rst(input int i);
      logic [3:0] idx;
      idx = 4'(i % 16);
      case (idx)
         `TTQ_IDX_CTRL: return `TTQ_CTRL_RST;
         `TTQ_IDX_WIN_WIDTH: return 32'(`TTQ_TICKS(`TTQ_WIN_WIDTH_RST_PS));
         `TTQ_IDX_TO_TIME: return 32'(`TTQ_TICKS(`TTQ_TO_TIME_RST_PS));
         `TTQ_IDX_IV_WIDTH: return 32'(`TTQ_TICKS(`TTQ_IV_WIDTH_RST_PS));
         `TTQ_IDX_SL_RATE: return 32'(`TTQ_TICKS(`TTQ_SL_RATE_RST_PS));
         `TTQ_IDX_WIN_DELTA, `TTQ_IDX_IV_DELTA, `TTQ_IDX_SL_DELTA: return 32'h0000_0000;
         default: return (idx < `TTQ_IDX_UPPER0) ? {16'h0000, `TTQ_LOWER_RST}
                                                 : {16'h0000, `TTQ_UPPER_RST};
      endcase
   endfunction : reg_rst

   // bus handshakes: address and data are taken independently
   assign s_axil_awready = !aw_v_q && !b_v_q;
   assign s_axil_wready = !w_v_q && !b_v_q;
   assign s_axil_arready = !r_v_q;
   assign s_axil_bvalid = b_v_q;
   assign s_axil_bresp = b_r_q;
   assign s_axil_rvalid = r_v_q;
   assign s_axil_rdata = r_d_q;
   assign s_axil_rresp = r_r_q;

   always_comb begin
      logic [7:0] wa;
      logic [7:0] ra;
      logic [3:0] widx;
      logic [1:0] wev;
      logic [3:0] ridx;
      int ri;
      wa = 8'(aw_a_q);
      ra = 8'(s_axil_araddr);
      widx = wa[5:2];
      wev = wa[7:6];
      ridx = ra[5:2];
      ri = 0;
      aw_v_d = aw_v_q;
      aw_a_d = aw_a_q;
      w_v_d = w_v_q;
      w_d_d = w_d_q;
      w_s_d = w_s_q;
      b_v_d = b_v_q;
      b_r_d = b_r_q;
      r_v_d = r_v_q;
      r_d_d = r_d_q;
      r_r_d = r_r_q;
      cfg_wr_d = '0;
      for (int i = 0; i < NREG; i++) begin
         regs_d[i] = regs_q[i];
      end
      if (s_axil_awvalid && s_axil_awready) begin
         aw_v_d = 1'b1;
         aw_a_d = s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
         w_v_d = 1'b1;
         w_d_d = s_axil_wdata;
         w_s_d = s_axil_wstrb;
      end
      if (s_axil_bvalid && s_axil_bready) begin
         b_v_d = 1'b0;
      end
      if (aw_v_q && w_v_q && !b_v_q) begin
         aw_v_d = 1'b0;
         w_v_d = 1'b0;
         b_v_d = 1'b1;
         if (wa < `TTQ_STAT_BASE && wa[1:0] == 2'b00) begin
            ri = 16 * int'(wev) + int'(widx);
            regs_d[ri] = merge(regs_q[ri], w_d_q, w_s_q);
            if (widx >= `TTQ_IDX_LOWER0) begin
               regs_d[ri] = clamp_mv(regs_d[ri]);
            end
            if (widx == `TTQ_IDX_CTRL) begin
               cfg_wr_d[wev] = 1'b1;
            end
            b_r_d = `TTQ_RESP_OKAY;
         end else begin
            b_r_d = `TTQ_RESP_SLVERR;
         end
      end
      if (s_axil_rvalid && s_axil_rready) begin
         r_v_d = 1'b0;
      end
      if (s_axil_arvalid && s_axil_arready) begin
         r_v_d = 1'b1;
         r_r_d = `TTQ_RESP_OKAY;
         r_d_d = 32'h0000_0000;
         if (ra[1:0] != 2'b00) begin
            r_r_d = `TTQ_RESP_SLVERR;
         end else if (ra < `TTQ_STAT_BASE) begin
            r_d_d = regs_q[16 * int'(ra[7:6]) + int'(ridx)];
         end else if (ra < `TTQ_STAT_LEVELS) begin
            ri = int'(ra - `TTQ_STAT_BASE) / 8;
            r_d_d = ra[2] ? {16'h0000, count_q[ri]} : 32'(last_q[ri]);
         end else if (ra == `TTQ_STAT_LEVELS) begin
            r_d_d = 32'(cmp_sv);
         end else begin
            r_r_d = `TTQ_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         aw_v_q <= 1'b0;
         aw_a_q <= '0;
         w_v_q <= 1'b0;
         w_d_q <= 32'h0000_0000;
         w_s_q <= 4'h0;
         b_v_q <= 1'b0;
         b_r_q <= `TTQ_RESP_OKAY;
         r_v_q <= 1'b0;
         r_d_q <= 32'h0000_0000;
         r_r_q <= `TTQ_RESP_OKAY;
         cfg_wr_q <= '0;
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= reg_rst(i);
         end
      end else if (ce_i) begin
         aw_v_q <= aw_v_d;
         aw_a_q <= aw_a_d;
         w_v_q <= w_v_d;
         w_d_q <= w_d_d;
         w_s_q <= w_s_d;
         b_v_q <= b_v_d;
         b_r_q <= b_r_d;
         r_v_q <= r_v_d;
         r_d_q <= r_d_d;
         r_r_q <= r_r_d;
         cfg_wr_q <= cfg_wr_d;
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   // one engine per event, each with its own settings block
   for (genvar e = 0; e < NEV; e++) begin : g_ev
      for (genvar c = 0; c < NCH; c++) begin : g_thr
         assign thr_o[e*NCH+c] = '{lower_mv: regs_q[16*e+8+c][15:0],
                                   upper_mv: regs_q[16*e+12+c][15:0]};
      end

      ttq_cfg_type cfg;
      logic [31:0] cw;
      ttq_cmp_type cur, prv_q, prv_d;
      logic [CNT_W-1:0] cnt_q, cnt_d, cnt_inc, width, delta;
      logic arm_q, arm_d, done_q, done_d, dir_q, dir_d, hit;
      ttq_judge_type jmode;

      assign cw = regs_q[16*e];
      assign cfg = '{enable: cw[`TTQ_F_EN],
                     qual: ttq_qual_type'(cw[`TTQ_F_TYPE +: 2]),
                     src: cw[`TTQ_F_SRC +: 2],
                     vert: ttq_vert_type'(cw[`TTQ_F_VERT +: 2]),
                     win_time: ttq_judge_type'(cw[`TTQ_F_WTIME +: 2]),
                     to_cond: ttq_level_type'(cw[`TTQ_F_TOCOND +: 2]),
                     iv_mode: ttq_judge_type'(cw[`TTQ_F_IVMODE +: 2]),
                     iv_edge: ttq_edge_type'(cw[`TTQ_F_IVEDGE +: 2]),
                     sl_slope: ttq_edge_type'(cw[`TTQ_F_SLSLOPE +: 2]),
                     sl_mode: ttq_judge_type'(cw[`TTQ_F_SLMODE +: 2])};
      assign cur = cmp_s[e*NCH + int'(cfg.src)];
      assign cnt_inc = (&cnt_q) ? cnt_q : cnt_q + 1'b1;

      // width and delta per qualifier; window width is the centre or a limit
      always_comb begin
         case (cfg.qual)
            QT_INTERVAL: begin
               jmode = cfg.iv_mode;
               width = CNT_W'(regs_q[16*e+int'(`TTQ_IDX_IV_WIDTH)]);
               delta = CNT_W'(regs_q[16*e+int'(`TTQ_IDX_IV_DELTA)]);
            end
            QT_SLEW: begin
               jmode = cfg.sl_mode;
               width = CNT_W'(regs_q[16*e+int'(`TTQ_IDX_SL_RATE)]);
               delta = CNT_W'(regs_q[16*e+int'(`TTQ_IDX_SL_DELTA)]);
            end
            default: begin
               jmode = cfg.win_time;
               width = CNT_W'(regs_q[16*e+int'(`TTQ_IDX_WIN_WIDTH)]);
               delta = CNT_W'(regs_q[16*e+int'(`TTQ_IDX_WIN_DELTA)]);
            end
         endcase
      end

      ttq_judge #(.W(CNT_W)) u_judge (
         .mode_i(jmode),
         .dur_i(cnt_q),
         .width_i(width),
         .delta_i(delta),
         .hit_o(hit)
      );

      always_comb begin
         logic ins, pins, st, pst, lvl_ok, edge_hit, stop;
         ins = !cur.above_upper && !cur.below_lower;
         pins = !prv_q.above_upper && !prv_q.below_lower;
         st = (cfg.vert == VM_OUTSIDE) ? !ins : ins;
         pst = (cfg.vert == VM_OUTSIDE) ? !pins : pins;
         lvl_ok = 1'b0;
         edge_hit = 1'b0;
         stop = 1'b0;
         prv_d = cur;
         cnt_d = cnt_q;
         arm_d = arm_q;
         done_d = done_q;
         dir_d = dir_q;
         fire[e] = 1'b0;
         meas_v[e] = 1'b0;
         meas[e] = cnt_q;
         if (cfg_wr_q[e] || !cfg.enable) begin
            cnt_d = '0;
            arm_d = 1'b0;
            done_d = 1'b0;
         end else begin
            case (cfg.qual)
               QT_WINDOW: begin
                  if (cfg.vert == VM_ENTER) begin
                     fire[e] = ins && !pins;
                  end else if (cfg.vert == VM_EXIT) begin
                     fire[e] = !ins && pins;
                  end else if (st) begin
                     cnt_d = pst ? cnt_inc : CNT_W'(1);
                     if (cfg.win_time == JM_LONGER && !done_q && cnt_d > width) begin
                        fire[e] = 1'b1;
                        done_d = 1'b1;
                     end
                  end else begin
                     cnt_d = '0;
                     done_d = 1'b0;
                     if (pst) begin
                        meas_v[e] = 1'b1;
                        fire[e] = (cfg.win_time != JM_LONGER) && hit;
                     end
                  end
               end
               QT_TIMEOUT: begin
                  case (cfg.to_cond)
                     LC_HIGH: lvl_ok = cur.above_upper;
                     LC_LOW: lvl_ok = !cur.above_upper;
                     LC_ANY: lvl_ok = 1'b1;
                     default: lvl_ok = 1'b0;
                  endcase
                  if (!lvl_ok || cur.above_upper != prv_q.above_upper) begin
                     cnt_d = lvl_ok ? CNT_W'(1) : '0;
                     done_d = 1'b0;
                  end else begin
                     cnt_d = cnt_inc;
                  end
                  if (lvl_ok && !done_d &&
                      cnt_d >= CNT_W'(regs_q[16*e+int'(`TTQ_IDX_TO_TIME)])) begin
                     fire[e] = 1'b1;
                     done_d = 1'b1;
                  end
               end
               QT_INTERVAL: begin
                  case (cfg.iv_edge)
                     ED_RISE: edge_hit = cur.above_upper && !prv_q.above_upper;
                     ED_FALL: edge_hit = !cur.above_upper && prv_q.above_upper;
                     ED_ANY: edge_hit = cur.above_upper != prv_q.above_upper;
                     default: edge_hit = 1'b0;
                  endcase
                  cnt_d = cnt_inc;
                  if (edge_hit) begin
                     if (arm_q) begin
                        meas_v[e] = 1'b1;
                        fire[e] = hit;
                     end
                     cnt_d = CNT_W'(1);
                     arm_d = 1'b1;
                  end
               end
               default: begin
                  if (!arm_q) begin
                     if (prv_q.below_lower && !cur.below_lower && cfg.sl_slope != ED_FALL) begin
                        arm_d = 1'b1;
                        dir_d = 1'b1;
                        cnt_d = CNT_W'(1);
                     end else if (prv_q.above_upper && !cur.above_upper &&
                                  cfg.sl_slope != ED_RISE) begin
                        arm_d = 1'b1;
                        dir_d = 1'b0;
                        cnt_d = CNT_W'(1);
                     end
                  end else begin
                     cnt_d = cnt_inc;
                     stop = dir_q ? (cur.above_upper && !prv_q.above_upper)
                                  : (cur.below_lower && !prv_q.below_lower);
                     if (stop) begin
                        arm_d = 1'b0;
                        meas_v[e] = 1'b1;
                        fire[e] = hit;
                     end else if (dir_q ? cur.below_lower : cur.above_upper) begin
                        arm_d = 1'b0;
                     end
                  end
               end
            endcase
         end
      end

      always_ff @(posedge ref_clk_i) begin
         if (!rst_n_i) begin
            prv_q <= '0;
            cnt_q <= '0;
            arm_q <= 1'b0;
            done_q <= 1'b0;
            dir_q <= 1'b0;
         end else if (ce_i) begin
            prv_q <= prv_d;
            cnt_q <= cnt_d;
            arm_q <= arm_d;
            done_q <= done_d;
            dir_q <= dir_d;
         end
      end
   end

   // status: last measured duration and saturating fire count
   always_comb begin
      for (int i = 0; i < NEV; i++) begin
         last_d[i] = meas_v[i] ? meas[i] : last_q[i];
         count_d[i] = (fire[i] && !(&count_q[i])) ? count_q[i] + 1'b1 : count_q[i];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         fire_q <= '0;
         for (int i = 0; i < NEV; i++) begin
            last_q[i] <= '0;
            count_q[i] <= 16'h0000;
         end
      end else if (ce_i) begin
         fire_q <= fire;
         for (int i = 0; i < NEV; i++) begin
            last_q[i] <= last_d[i];
            count_q[i] <= count_d[i];
         end
      end
   end

   assign trig_o = fire_q;
endmodule : ttq_top
`default_nettype wire

// >>> verif/ttq_props.sv
// port checks for the trigger time qualifier
`timescale 1ns/1ps
`default_nettype none
module ttq_props (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire ttq_pkg::ttq_thr_type [11:0] thr_o,
   input wire logic [2:0] trig_o,
   input wire logic s_axil_awvalid,
   input wire logic s_axil_awready,
   input wire logic s_axil_wvalid,
   input wire logic s_axil_wready,
   input wire logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic s_axil_arvalid,
   input wire logic s_axil_arready,
   input wire logic s_axil_rvalid,
   input wire logic s_axil_rready
);
   import ttq_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_b_hold; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_r_hold; s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid; endproperty
   a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
   property p_rd_lat; s_axil_arvalid && s_axil_arready && ce_i |=> s_axil_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("late read");
   property p_wr_lat;
      s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##[1:2] s_axil_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("late write");
   property p_aw_ref; s_axil_bvalid |-> !s_axil_awready && !s_axil_wready; endproperty
   a_aw_ref: assert property (p_aw_ref) else $error("write taken early");
   property p_ar_ref; s_axil_rvalid |-> !s_axil_arready; endproperty
   a_ar_ref: assert property (p_ar_ref) else $error("read taken early");
   property p_pulse; trig_o != 3'h0 && ce_i |=> (trig_o & $past(trig_o)) == 3'h0; endproperty
   a_pulse: assert property (p_pulse) else $error("trigger too long");
   property p_rst;
      $rose(rst_n_i) |-> trig_o == 3'h0 && thr_o[0].lower_mv == 16'hff9c &&
         thr_o[11].upper_mv == 16'h0064;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   c_trig: cover property (trig_o != 3'h0);
   c_wr: cover property (s_axil_bvalid && s_axil_bready);
   c_rd: cover property (s_axil_rvalid && s_axil_rready);
endmodule : ttq_props
bind ttq_top ttq_props chk (.*);
`default_nettype wire

// >>> verif/ttq_cmp_model.sv
// comparator model: one test voltage against every event and channel window
`timescale 1ns/1ps
`default_nettype none
module ttq_cmp_model (
   input wire ttq_pkg::ttq_thr_type [11:0] thr_i,
   input wire logic signed [15:0] mv_i,
   output ttq_pkg::ttq_cmp_type [11:0] cmp_o
);
   import ttq_pkg::*;
   always_comb begin
      for (int k = 0; k < 12; k++) begin
         cmp_o[k].above_upper = mv_i > $signed(thr_i[k].upper_mv);
         cmp_o[k].below_lower = mv_i < $signed(thr_i[k].lower_mv);
      end
   end
endmodule : ttq_cmp_model
`default_nettype wire

// >>> verif/ttq_top_tb.sv
// self-checking bench for the trigger time qualifier
`timescale 1ns/1ps
`default_nettype none
module ttq_top_tb;
   import ttq_pkg::*;
   logic clk = 0, rst_n = 0, ce = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic awr, wrd, bv, arr, rv;
   logic [7:0] aa = 0, ra = 0;
   logic [31:0] wd = 0, rdat;
   logic [1:0] br, rr, resp;
   logic [2:0] trig;
   logic signed [15:0] mv = 500;
   ttq_thr_type [11:0] thr;
   ttq_cmp_type [11:0] cmp;
   int errors = 0, n_tests = 0, fires = 0, ev = 0;
   int ofs[7] = '{0, 4, 12, 16, 24, 32, 60};
   logic [31:0] rv0[7] = '{32'h0003_0400, 1, 20, 1, 1, 32'h0000_ff9c, 32'h0000_0064};
   int dl[4] = '{4, 10, 14, 20};
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (trig[ev]) fires++;
   ttq_top uut (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .cmp_i(cmp), .thr_o(thr),
      .trig_o(trig), .s_axil_awaddr(aa), .s_axil_awvalid(awv), .s_axil_awready(awr),
      .s_axil_wdata(wd), .s_axil_wstrb(4'hf), .s_axil_wvalid(wv), .s_axil_wready(wrd),
      .s_axil_bresp(br), .s_axil_bvalid(bv), .s_axil_bready(bry), .s_axil_araddr(ra),
      .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rdat), .s_axil_rresp(rr),
      .s_axil_rvalid(rv), .s_axil_rready(rry));
   ttq_cmp_model far (.thr_i(thr), .mv_i(mv), .cmp_o(cmp));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input int a, input logic [31:0] d);
      aa <= a[7:0];
      wd <= d;
      awv <= 1;
      wv <= 1;
      do begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (awv || wv);
      while (!bv) @(posedge clk);
      bry <= 1;
      @(posedge clk);
      resp = br;
      bry <= 0;
   endtask : wr
   task automatic rd(input int a, input logic [31:0] e);
      ra <= a[7:0];
      arv <= 1;
      do @(posedge clk); while (!arr);
      arv <= 0;
      do @(posedge clk); while (!rv);
      rry <= 1;
      @(posedge clk);
      chk(rdat, e);
      chk(rr, 2'b00);
      rry <= 0;
   endtask : rd
   function automatic int hit(int m, int d);
      case (m)
         0: return d >= 8 && d <= 16;
         1: return d < 8 || d > 16;
         2: return d < 12;
         default: return d > 12;
      endcase
   endfunction : hit
   task automatic run(input logic [31:0] c, input int lo, hi, d, iv);
      mv <= 16'(lo);
      wr(ev * 64, c);
      repeat (6) @(posedge clk);
      fires = 0;
      mv <= 16'(hi);
      repeat (iv ? 2 : d) @(posedge clk);
      mv <= 16'(lo);
      if (iv) begin
         repeat (d - 2) @(posedge clk);
         mv <= 16'(hi);
         repeat (2) @(posedge clk);
         mv <= 16'(lo);
      end
      repeat (12) @(posedge clk);
   endtask : run
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      print_verdict();
   end
   initial begin
      int t;
      void'($urandom(32'ha1f4ae52));
      repeat (6) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      foreach (ofs[i]) for (int e = 0; e < 3; e++) begin
         rd(e * 64 + ofs[i], rv0[i]);
      end
      $display("reset values done");
      wr(96, -20000);
      rd(96, 32'h0000_d8f0);
      chk(thr[4].lower_mv, 32'h0000_d8f0);
      wr(96, -100);
      wr(192, 0);
      chk(resp, 2'b10);
      rd(216, 32'h00aa_aaaa);
      $display("threshold test done");
      ev = $urandom % 3;
      for (int k = 0; k < 3; k++) begin
         t = 14 + $urandom % 8;
         wr(ev * 64 + 12, t);
         run(32'h8000_0001 | (k << 8), k == 1 ? 500 : 0, k == 1 ? 0 : 500, 3 * t, 0);
         chk(fires, 1);
      end
      $display("timeout test done");
      ev = $urandom % 3;
      wr(ev * 64 + 4, 12);
      wr(ev * 64 + 8, 4);
      wr(ev * 64 + 16, 12);
      wr(ev * 64 + 20, 4);
      for (int m = 0; m < 4; m++) foreach (dl[i]) begin
         run(32'h8000_0020 | (m << 6), 500, 0, dl[i], 0);
         chk(fires, hit(m, dl[i]));
         rd(192 + 8 * ev, dl[i]);
         run(32'h8000_0030 | (m << 6), 0, 500, dl[i], 0);
         chk(fires, hit(m, dl[i]));
         run(32'h8000_0002 | (m << 10), 0, 500, dl[i], 1);
         chk(fires, hit(m, dl[i]));
         rd(192 + 8 * ev, dl[i]);
      end
      $display("window and interval test done");
      print_verdict();
   end
endmodule : ttq_top_tb
`default_nettype wire
